// *** logic/sriov_cfg_consts.vh ***
// Constants for the SR-IOV function configuration and extension bus block.
// Included by the block's design file; holds definitions only.
`ifndef SRIOV_CFG_CONSTS_VH
`define SRIOV_CFG_CONSTS_VH

// Register map, byte addresses on the plain register port
`define REG_FUNC_CFG    8'h00
`define REG_VF_CNT_BASE 8'h10
`define REG_PAGE_SIZE   8'h30
`define REG_STD_PTR     8'h34
`define REG_EXT_PTR     8'h38
`define REG_ACK_LAT     8'h3c
`define REG_STATUS      8'h40
`define REG_FLR         8'h44
`define REG_CAP_SEL     8'h48

// Function control fields
`define FC_NUM_PF_LSB   0
`define FC_SRIOV_BIT    4
`define FC_ARI_BIT      5
`define FC_FLR_BIT      6
`define FC_TPH_PF_BIT   7
`define FC_TPH_VF_BIT   8
`define FC_ATS_PF_BIT   9
`define FC_ATS_VF_BIT   10
`define FC_EXT_BIT      11

// Limits and reset values
`define MAX_PF          4'd8
`define MAX_VF          12'd2048
`define MAX_ARI_FUNC    9'd256
`define FUNC_CFG_RST    12'h001
`define PAGE_SIZE_RST   11'h001
`define PAGE_SIZE_MASK  11'h7ff
`define PTR_RST         10'h000
`define EXT_PTR_MIN     10'h100
`define ACK_LAT_RST     3'h7
`define ACK_LAT_MIN     3'h1
`define VF_DW           12

`endif

// *** logic/sriov_func_cfg.v ***
// SR-IOV function configuration checker and configuration extension bus bridge.
// Assumes configuration requests come from the host-side config logic, one at a time,
// and that user logic on the extension bus answers with an acknowledge pulse.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`include "sriov_cfg_consts.vh"

module sriov_func_cfg (
   // Clock and reset
   input  wire        i_clk_sys,
   input  wire        i_sys_rst,
   // Register port
   input  wire [7:0]  i_reg_addr,
   input  wire [31:0] i_reg_wdata,
   input  wire        i_reg_wr,
   input  wire        i_reg_rd,
   output reg  [31:0] o_reg_rdata,
   // Configuration request from host side
   input  wire        i_cfg_req,
   input  wire        i_cfg_wr,
   input  wire        i_cfg_vf,
   input  wire [9:0]  i_cfg_dw_addr,
   input  wire [31:0] i_cfg_wdata,
   input  wire [3:0]  i_cfg_be,
   output wire        o_cfg_busy,
   output reg         o_cfg_cpl,
   output reg  [31:0] o_cfg_cpl_data,
   output reg  [2:0]  o_cfg_cpl_status,
   // Configuration extension bus
   output reg         o_config_extension_bus_req,
   output reg         o_config_extension_bus_wr,
   output reg         o_config_extension_bus_vf,
   output reg  [9:0]  o_config_extension_bus_addr,
   output reg  [31:0] o_config_extension_bus_wdata,
   output reg  [3:0]  o_config_extension_bus_be,
   input  wire        i_config_extension_bus_ack,
   input  wire [31:0] i_config_extension_bus_rdata,
   // Capability presence and pointers seen by the internal config space
   output wire        o_vf_enable,
   output wire        o_ari_enable,
   output wire [8:0]  o_max_func,
   output wire        o_tph_pf_present,
   output wire        o_tph_vf_present,
   output wire        o_ats_pf_present,
   output wire        o_ats_vf_present,
   output wire        o_ext_bus_enable,
   output wire [10:0] o_supported_page_sizes,
   output wire [9:0]  o_pf_std_next_ptr,
   output wire [9:0]  o_vf_std_next_ptr,
   output wire [9:0]  o_pf_ext_next_ptr,
   output wire [9:0]  o_vf_ext_next_ptr,
   // Configuration checks and per-function resets
   output wire        o_cfg_valid,
   output wire [7:0]  o_func_rst
);

   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_REQ  = 4'b0010;
   localparam [3:0] ST_WAIT = 4'b0100;
   localparam [3:0] ST_DONE = 4'b1000;

   reg  [11:0] func_cfg_q;
   reg  [10:0] page_size_q;
   reg  [9:0]  pf_std_ptr_q;
   reg  [9:0]  vf_std_ptr_q;
   reg  [9:0]  pf_ext_ptr_q;
   reg  [9:0]  vf_ext_ptr_q;
   reg  [2:0]  ack_lat_q;
   reg  [7:0]  flr_q;
   reg  [11:0] vf_cnt_q [0:7];
   reg  [3:0]  state_q;
   reg  [31:0] rdata_d;
   reg  [2:0]  tmo_cnt_q;
   reg         ptr_err_q;

   wire [3:0]  num_pf = func_cfg_q[`FC_NUM_PF_LSB +: 4];
   wire        sriov_on = func_cfg_q[`FC_SRIOV_BIT];
   wire [7:0]  pf_ok;
   wire [7:0]  pf_en;
   wire [15:0] vf_sum;
   wire [31:0] status_word;

   // VF count registers sit at base + 4*n; the index comes from the offset
   wire [7:0]  vf_off     = i_reg_addr - `REG_VF_CNT_BASE;
   wire [2:0]  vf_idx     = vf_off[4:2];
   wire        vf_hit     = (i_reg_addr >= `REG_VF_CNT_BASE) && (i_reg_addr < `REG_PAGE_SIZE)
                            && (i_reg_addr[1:0] == 2'b00);
   wire        ext_pf_ok  = (i_reg_wdata[9:0] >= `EXT_PTR_MIN);
   wire        ext_vf_ok  = (i_reg_wdata[25:16] >= `EXT_PTR_MIN);
   wire        ack_lat_ok = (i_reg_wdata[2:0] >= `ACK_LAT_MIN);

   // Step rule on a VF count by range
   function step_ok;
      input [15:0] n;
      begin
         if (n <= 16'd8)
            step_ok = 1'b1;
         else if (n <= 16'd256)
            step_ok = (n[1:0] == 2'd0);
         else if (n <= 16'd1024)
            step_ok = (n[5:0] == 6'd0);
         else if (n <= {4'h0, `MAX_VF})
            step_ok = (n[8:0] == 9'd0);
         else
            step_ok = 1'b0;
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_pf
         assign pf_en[g] = (g < num_pf);
         assign pf_ok[g] = step_ok({4'h0, vf_cnt_q[g]});
      end
   endgenerate

   assign vf_sum = (pf_en[0] ? {4'h0, vf_cnt_q[0]} : 16'h0)
                 + (pf_en[1] ? {4'h0, vf_cnt_q[1]} : 16'h0)
                 + (pf_en[2] ? {4'h0, vf_cnt_q[2]} : 16'h0)
                 + (pf_en[3] ? {4'h0, vf_cnt_q[3]} : 16'h0)
                 + (pf_en[4] ? {4'h0, vf_cnt_q[4]} : 16'h0)
                 + (pf_en[5] ? {4'h0, vf_cnt_q[5]} : 16'h0)
                 + (pf_en[6] ? {4'h0, vf_cnt_q[6]} : 16'h0)
                 + (pf_en[7] ? {4'h0, vf_cnt_q[7]} : 16'h0);

   wire pf_num_ok  = (num_pf != 4'd0) && (num_pf <= `MAX_PF);
   wire pf_cnt_ok  = &(pf_ok | ~pf_en);
   wire sum_ok     = (vf_sum <= {4'h0, `MAX_VF}) && step_ok(vf_sum);
   wire vf_zero_ok = sriov_on || (vf_sum == 16'h0);
   assign o_cfg_valid = pf_num_ok && pf_cnt_ok && sum_ok && vf_zero_ok && !ptr_err_q;

   // Status word: VF sum on top, one flag per failed check, valid in bit 0
   assign status_word = {vf_sum, 10'h000, ptr_err_q, !vf_zero_ok,
                         !sum_ok, !pf_cnt_ok, !pf_num_ok, o_cfg_valid};

   assign o_vf_enable       = sriov_on;
   assign o_ari_enable      = func_cfg_q[`FC_ARI_BIT];
   assign o_max_func        = func_cfg_q[`FC_ARI_BIT] ? `MAX_ARI_FUNC : {5'h0, `MAX_PF};
   assign o_tph_pf_present  = func_cfg_q[`FC_TPH_PF_BIT];
   assign o_tph_vf_present  = func_cfg_q[`FC_TPH_VF_BIT] & sriov_on;
   assign o_ats_pf_present  = func_cfg_q[`FC_ATS_PF_BIT];
   assign o_ats_vf_present  = func_cfg_q[`FC_ATS_VF_BIT] & sriov_on;
   assign o_ext_bus_enable  = func_cfg_q[`FC_EXT_BIT];
   assign o_supported_page_sizes = page_size_q;
   assign o_pf_std_next_ptr = pf_std_ptr_q;
   assign o_vf_std_next_ptr = vf_std_ptr_q;
   assign o_pf_ext_next_ptr = pf_ext_ptr_q;
   assign o_vf_ext_next_ptr = vf_ext_ptr_q;
   // Per-function reset, only where FLR is enabled and the PF exists
   assign o_func_rst = func_cfg_q[`FC_FLR_BIT] ? (flr_q & pf_en) : 8'h00;

   // Register writes
   integer k;
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         func_cfg_q   <= `FUNC_CFG_RST;
         page_size_q  <= `PAGE_SIZE_RST;
         pf_std_ptr_q <= `PTR_RST;
         vf_std_ptr_q <= `PTR_RST;
         pf_ext_ptr_q <= `PTR_RST;
         vf_ext_ptr_q <= `PTR_RST;
         ack_lat_q    <= `ACK_LAT_RST;
         for (k = 0; k < 8; k = k + 1)
            vf_cnt_q[k] <= 12'h000;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            `REG_FUNC_CFG: begin
               func_cfg_q <= i_reg_wdata[11:0];
            end
            `REG_PAGE_SIZE: begin
               page_size_q <= i_reg_wdata[10:0] & `PAGE_SIZE_MASK;
            end
            `REG_STD_PTR: begin
               pf_std_ptr_q <= i_reg_wdata[9:0];
               vf_std_ptr_q <= i_reg_wdata[25:16];
            end
            `REG_EXT_PTR: begin
               // A pointer below the extended space is refused as a pair
               if (ext_pf_ok && ext_vf_ok) begin
                  pf_ext_ptr_q <= i_reg_wdata[9:0];
                  vf_ext_ptr_q <= i_reg_wdata[25:16];
               end
            end
            `REG_ACK_LAT: begin
               // A zero latency would leave no acknowledge window, so it is ignored
               if (ack_lat_ok)
                  ack_lat_q <= i_reg_wdata[2:0];
            end
            default: begin
               if (vf_hit)
                  vf_cnt_q[vf_idx] <= i_reg_wdata[11:0];
            end
         endcase
      end
   end

   // Pointer error flag: set by a refused extended-pointer write, cleared by a legal one
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ptr_err_q <= 1'b0;
      end else if (i_reg_wr && (i_reg_addr == `REG_EXT_PTR)) begin
         ptr_err_q <= !(ext_pf_ok && ext_vf_ok);
      end
   end

   // Function-level reset: one pulse per written bit, never stretched
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flr_q <= 8'h00;
      end else if (i_reg_wr && (i_reg_addr == `REG_FLR)) begin
         flr_q <= i_reg_wdata[7:0];
      end else begin
         flr_q <= 8'h00;
      end
   end

   // Read mux; unmapped offsets read as zero
   always @* begin
      rdata_d = 32'h00000000;
      if (i_reg_rd) begin
         case (i_reg_addr)
            `REG_FUNC_CFG:  rdata_d = {20'h0, func_cfg_q};
            `REG_PAGE_SIZE: rdata_d = {21'h0, page_size_q};
            `REG_STD_PTR:   rdata_d = {6'h0, vf_std_ptr_q, 6'h0, pf_std_ptr_q};
            `REG_EXT_PTR:   rdata_d = {6'h0, vf_ext_ptr_q, 6'h0, pf_ext_ptr_q};
            `REG_ACK_LAT:   rdata_d = {29'h0, ack_lat_q};
            `REG_STATUS:    rdata_d = status_word;
            `REG_CAP_SEL:   rdata_d = {23'h0, o_max_func};
            default: begin
               if (vf_hit)
                  rdata_d = {20'h0, vf_cnt_q[vf_idx]};
            end
         endcase
      end
   end

   // Read data stands for exactly the cycle after the strobe
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 32'h00000000;
      end else begin
         o_reg_rdata <= rdata_d;
      end
   end

   // Extension bus request, timeout and completion.
   // The request cycle itself is not part of the acknowledge window, so a
   // latency of L gives user logic the L cycles after the request.
   wire issue    = (state_q == ST_IDLE) && i_cfg_req && o_ext_bus_enable;
   wire ack_seen = (state_q == ST_WAIT) && i_config_extension_bus_ack;
   wire tmo_last = (state_q == ST_WAIT) && (tmo_cnt_q == 3'h1);

   // Busy covers the request, wait and completion cycles
   assign o_cfg_busy = (state_q != ST_IDLE);

   // Request fields, held until the next request
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_config_extension_bus_req   <= 1'b0;
         o_config_extension_bus_wr    <= 1'b0;
         o_config_extension_bus_vf    <= 1'b0;
         o_config_extension_bus_addr  <= 10'h000;
         o_config_extension_bus_wdata <= 32'h00000000;
         o_config_extension_bus_be    <= 4'h0;
      end else begin
         o_config_extension_bus_req <= issue;
         if (issue) begin
            o_config_extension_bus_wr    <= i_cfg_wr;
            o_config_extension_bus_vf    <= i_cfg_vf & sriov_on;
            o_config_extension_bus_addr  <= i_cfg_dw_addr;
            o_config_extension_bus_wdata <= i_cfg_wdata;
            o_config_extension_bus_be    <= i_cfg_be;
         end
      end
   end

   // Sequencer and latency counter
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q   <= ST_IDLE;
         tmo_cnt_q <= 3'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (issue) begin
                  tmo_cnt_q <= ack_lat_q;
                  state_q   <= ST_REQ;
               end
            end
            ST_REQ: begin
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               if (ack_seen || tmo_last)
                  state_q <= ST_DONE;
               else
                  tmo_cnt_q <= tmo_cnt_q - 3'h1;
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Completion to the host: user data on an acknowledged read, all zeros on an acknowledged write or on timeout
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_cfg_cpl        <= 1'b0;
         o_cfg_cpl_data   <= 32'h00000000;
         o_cfg_cpl_status <= 3'h0;
      end else begin
         o_cfg_cpl <= ack_seen || tmo_last;
         if (ack_seen) begin
            // A write completes with zero data; a read carries the user data
            o_cfg_cpl_data   <= o_config_extension_bus_wr ? 32'h00000000
                                : i_config_extension_bus_rdata;
            o_cfg_cpl_status <= 3'h0;
         end else if (tmo_last) begin
            o_cfg_cpl_data   <= 32'h00000000;
            o_cfg_cpl_status <= 3'h0;
         end
      end
   end

endmodule // sriov_func_cfg

// *** dv/sriov_func_cfg_props.sv ***
// Concurrent checks on the ports of the SR-IOV function configuration block.
// Assumes one clock domain; attached to the block by the bind at the foot.
module sriov_func_cfg_props (
   // Clock and reset
   input logic        i_clk_sys,
   input logic        i_sys_rst,
   // Register port
   input logic [7:0]  i_reg_addr,
   input logic [31:0] i_reg_wdata,
   input logic        i_reg_wr,
   // Requests, completions and extension bus
   input logic        i_cfg_req,
   input logic        o_cfg_busy,
   input logic        o_cfg_cpl,
   input logic [31:0] o_cfg_cpl_data,
   input logic        o_config_extension_bus_req,
   input logic        o_config_extension_bus_wr,
   input logic        i_config_extension_bus_ack,
   input logic [31:0] i_config_extension_bus_rdata,
   // Capability outputs and resets
   input logic        o_vf_enable,
   input logic        o_ari_enable,
   input logic [8:0]  o_max_func,
   input logic        o_tph_vf_present,
   input logic        o_ats_vf_present,
   input logic        o_ext_bus_enable,
   input logic [9:0]  o_pf_ext_next_ptr,
   input logic [7:0]  o_func_rst
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   a_req_taken: assert property (
      i_cfg_req && !o_cfg_busy && o_ext_bus_enable |=> o_config_extension_bus_req && o_cfg_busy)
      else $error("extension request not issued");
   a_req_cause: assert property (
      o_config_extension_bus_req |-> $past(i_cfg_req && !o_cfg_busy && o_ext_bus_enable))
      else $error("extension request without a taken request");
   a_req_pulse: assert property (
      o_config_extension_bus_req |=> !o_config_extension_bus_req [*3])
      else $error("extension request too long or too close");
   a_ack_cpl: assert property (
      o_config_extension_bus_req ##1 i_config_extension_bus_ack |=> o_cfg_cpl &&
      o_cfg_cpl_data == (o_config_extension_bus_wr ? 32'h0 : $past(i_config_extension_bus_rdata)))
      else $error("completion does not follow acknowledge");
   a_cpl_bound: assert property (o_config_extension_bus_req |-> ##[2:8] o_cfg_cpl)
      else $error("no completion within the latency window");
   a_tmo_zero: assert property (
      o_cfg_cpl && !$past(i_config_extension_bus_ack) |-> o_cfg_cpl_data == 32'h0)
      else $error("timeout completion data not zero");
   a_max_func: assert property (o_max_func == (o_ari_enable ? 9'd256 : 9'd8))
      else $error("function count wrong");
   a_vf_gate: assert property (!o_vf_enable |-> !o_tph_vf_present && !o_ats_vf_present)
      else $error("virtual capability without virtual functions");
   a_ext_ptr: assert property (o_pf_ext_next_ptr == 10'h0 || o_pf_ext_next_ptr >= 10'h100)
      else $error("extended pointer below minimum");
   a_flr_cause: assert property (o_func_rst != 8'h0 |-> $past(i_reg_wr && i_reg_addr == 8'h44)
      && (o_func_rst & ~$past(i_reg_wdata[7:0])) == 8'h0)
      else $error("function reset without request");
   c_ack: cover property (o_config_extension_bus_req ##1 i_config_extension_bus_ack);
   c_tmo: cover property (o_cfg_cpl && !$past(i_config_extension_bus_ack));
   c_flr: cover property (o_func_rst != 8'h0);
endmodule // sriov_func_cfg_props
bind sriov_func_cfg sriov_func_cfg_props u_props (.*);

// *** dv/ceb_user_model.sv ***
// User logic model on the configuration extension bus.
// Assumes request fields stay held after the one-cycle request pulse.
module ceb_user_model (
   // Clock and reset
   input  wire        i_clk_sys,
   input  wire        i_sys_rst,
   // Request from the block; delay 0 never answers
   input  wire        i_req,
   input  wire        i_wr,
   input  wire [9:0]  i_addr,
   input  wire [31:0] i_wdata,
   input  wire [3:0]  i_delay,
   // Answer
   output reg         o_ack,
   output reg  [31:0] o_rdata
);
   reg  [31:0] mem_q [0:15];
   reg  [3:0]  cnt_q;
   wire [3:0]  cnt_d = i_req ? i_delay : cnt_q;
   wire        fire  = (cnt_d == 4'h1);
   always @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= 4'h0;
         o_ack <= 1'b0;
         o_rdata <= 32'h0;
      end else begin
         cnt_q <= (cnt_d > 4'h1) ? cnt_d - 4'h1 : 4'h0;
         o_ack <= fire;
         // Data line never rests on the last value outside an answer
         o_rdata <= fire && !i_wr ? mem_q[i_addr[3:0]] : ~o_rdata;
         if (fire && i_wr) mem_q[i_addr[3:0]] <= i_wdata;
      end
   end
endmodule // ceb_user_model

// *** dv/test_sriov_func_cfg.sv ***
// Self-checking bench for the SR-IOV function configuration block.
// Assumes the block's register map and the user logic model beside it.
module test_sriov_func_cfg;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 0, i_sys_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_cfg_req = 0, i_cfg_wr = 0;
   logic i_cfg_vf = 0, rd_d = 0, o_cfg_busy, o_cfg_cpl, o_vf_enable, o_ari_enable, o_cfg_valid;
   logic o_config_extension_bus_req, o_config_extension_bus_wr, o_config_extension_bus_vf;
   logic o_tph_pf_present, o_tph_vf_present, o_ats_pf_present, o_ats_vf_present, o_ext_bus_enable;
   logic        i_config_extension_bus_ack;
   logic [2:0]  o_cfg_cpl_status;
   logic [3:0]  i_cfg_be = 4'hf, o_config_extension_bus_be, dly = 4'h1;
   logic [7:0]  i_reg_addr = 8'h0, o_func_rst;
   logic [8:0]  o_max_func;
   logic [9:0]  i_cfg_dw_addr = 10'h0, o_config_extension_bus_addr, o_pf_std_next_ptr;
   logic [9:0]  o_vf_std_next_ptr, o_pf_ext_next_ptr, o_vf_ext_next_ptr;
   logic [10:0] o_supported_page_sizes;
   logic [31:0] i_reg_wdata = 0, i_cfg_wdata = 0, o_reg_rdata, o_cfg_cpl_data, v0, v1, sum;
   logic [31:0] o_config_extension_bus_wdata, i_config_extension_bus_rdata, exp_rd[$], exp_cpl[$];
   int failures = 0, compares = 0, seed = 57515;
   logic [31:0] exp_bus[$], bus_f;
   assign bus_f = {17'h0, o_config_extension_bus_vf, o_config_extension_bus_be,
                   o_config_extension_bus_addr};
   int vt0[9] = '{8, 12, 260, 320, 2048, 1024, 2048, 256, 5};
   int vt1[9] = '{0, 0, 0, 0, 0, 1024, 4, 12, 3};
   logic [3:0] pf_tab[5] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hf}, lt[3] = '{4'h1, 4'h7, 4'h3};
   sriov_func_cfg u_sriov_func_cfg (.*);
   ceb_user_model u_ceb_user_model (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .i_req(o_config_extension_bus_req), .i_wr(o_config_extension_bus_wr),
      .i_addr(o_config_extension_bus_addr), .i_wdata(o_config_extension_bus_wdata),
      .i_delay(dly), .o_ack(i_config_extension_bus_ack), .o_rdata(i_config_extension_bus_rdata));
   always #2 i_clk_sys = ~i_clk_sys;
   function automatic bit ok(input logic [31:0] n);
      return n <= 8 || (n <= 256 && n % 4 == 0) || (n <= 1024 && n % 64 == 0) || n % 512 == 0;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One register access; a read notes its expected data
   task automatic acc(input bit w, input [7:0] a, input [31:0] d);
      if (!w) exp_rd.push_back(d);
      @(posedge i_clk_sys);
      {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {w, !w, a, d};
      @(posedge i_clk_sys);
      {i_reg_wr, i_reg_rd} <= 2'b00;
   endtask
   // One configuration request, answered by the model after dl cycles, never when dl is 0
   task automatic cfg(input bit w, input [9:0] a, input [31:0] d, input [3:0] dl, input [31:0] e);
      int n = 0;
      logic [31:0] r;
      r = $random(seed);
      exp_cpl.push_back(e);
      // The VF bit must stay low while virtualization is off
      exp_bus.push_back({17'h0, 1'b0, r[3:0], a});
      @(posedge i_clk_sys);
      {i_cfg_req, i_cfg_wr, i_cfg_dw_addr, i_cfg_wdata, dly} <= {1'b1, w, a, d, dl};
      {i_cfg_vf, i_cfg_be} <= r[4:0];
      @(posedge i_clk_sys);
      i_cfg_req <= 1'b0;
      while (!o_cfg_cpl && n < 20) begin
         @(posedge i_clk_sys);
         n++;
      end
      if (n == 20) begin
         failures++;
         wrap_up();
      end
   endtask
   always @(posedge i_clk_sys) begin
      if (rd_d) chk("register read", exp_rd.pop_front(), o_reg_rdata);
      rd_d <= i_reg_rd;
      if (o_cfg_cpl) begin
         chk("cpl status", 32'h0, {29'h0, o_cfg_cpl_status});
         if (exp_cpl.size() == 0) chk("spare cpl", 32'h0, 32'h1);
         else chk("cpl data", exp_cpl.pop_front(), o_cfg_cpl_data);
      end
      if (o_config_extension_bus_req) begin
         chk("busy", 32'h1, {31'h0, o_cfg_busy});
         if (exp_bus.size() == 0) chk("spare bus req", 32'h0, 32'h1);
         else chk("bus fields", exp_bus.pop_front(), bus_f);
      end
   end
   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      acc(0, 8'h00, 32'h1);
      acc(0, 8'h30, 32'h1);
      acc(0, 8'h3c, 32'h7);
      acc(0, 8'h48, 32'h8);
      acc(0, 8'h4c, 32'h0);
      foreach (pf_tab[i]) begin
         acc(1, 8'h00, {28'h0, pf_tab[i]});
         acc(0, 8'h40, (pf_tab[i] inside {[1:8]}) ? 32'h1 : 32'h2);
      end
      acc(1, 8'h00, 32'h12);
      for (int i = 0; i < 15; i++) begin
         v0 = i < 9 ? vt0[i] : ($random(seed) & 32'h7) << ((i % 4) * 2 + 2);
         v1 = i < 9 ? vt1[i] : ($random(seed) & 32'h3f) << 2;
         sum = v0 + v1;
         acc(1, 8'h10, v0);
         acc(1, 8'h14, v1);
         acc(0, 8'h40, {sum[15:0], 12'h0, !(ok(sum) && sum <= 2048),
            !(ok(v0) && ok(v1)), 1'b0, ok(v0) && ok(v1) && ok(sum) && sum <= 2048});
      end
      acc(1, 8'h10, 32'h8);
      acc(1, 8'h00, 32'h2);
      #1 chk("vf off", 32'h0, {o_cfg_valid, o_vf_enable});
      acc(1, 8'h10, 32'h0);
      acc(1, 8'h14, 32'h0);
      acc(1, 8'h00, 32'hff1);
      acc(0, 8'h48, 32'h100);
      #1 chk("caps on", 32'h1ff, {o_vf_enable, o_ari_enable, o_tph_pf_present, o_tph_vf_present,
         o_ats_pf_present, o_ats_vf_present, o_ext_bus_enable, o_max_func[8], o_cfg_valid});
      acc(1, 8'h00, 32'hf81);
      #1 chk("caps pf", 32'h055, {o_vf_enable, o_ari_enable, o_tph_pf_present, o_tph_vf_present,
         o_ats_pf_present, o_ats_vf_present, o_ext_bus_enable, o_max_func[8], o_cfg_valid});
      v0 = $random(seed) & 32'h7ff;
      acc(1, 8'h30, v0);
      #1 chk("page sizes", v0, {21'h0, o_supported_page_sizes});
      acc(1, 8'h34, 32'h0050_0040);
      acc(1, 8'h38, 32'h0120_0100);
      acc(1, 8'h38, 32'h0200_00ff);
      acc(0, 8'h34, 32'h0050_0040);
      acc(0, 8'h38, 32'h0120_0100);
      #1 chk("vf ext ptr", 32'h120, {22'h0, o_vf_ext_next_ptr});
      chk("std ptrs", 32'h0001_4040, {12'h0, o_vf_std_next_ptr, o_pf_std_next_ptr});
      chk("ext ptrs", 32'h0004_8100, {12'h0, o_vf_ext_next_ptr, o_pf_ext_next_ptr});
      acc(1, 8'h00, 32'h044);
      acc(1, 8'h44, 32'hff);
      #1 chk("flr pulse", 32'h0f, {24'h0, o_func_rst});
      @(posedge i_clk_sys);
      #1 chk("flr end", 32'h0, {24'h0, o_func_rst});
      acc(1, 8'h00, 32'h004);
      acc(1, 8'h44, 32'hff);
      #1 chk("flr off", 32'h0, {24'h0, o_func_rst});
      @(posedge i_clk_sys);
      i_cfg_req <= 1'b1;
      @(posedge i_clk_sys);
      i_cfg_req <= 1'b0;
      repeat (12) @(posedge i_clk_sys);
      acc(1, 8'h00, 32'h801);
      acc(1, 8'h3c, 32'h0);
      acc(0, 8'h3c, 32'h7);
      foreach (lt[i]) begin
         acc(1, 8'h3c, {28'h0, lt[i]});
         v0 = $random(seed);
         cfg(1, {6'h0, lt[i]}, v0, 4'h1, 32'h0);
         cfg(0, {6'h0, lt[i]}, 32'h0, lt[i], v0);
         cfg(0, {6'h0, lt[i]}, 32'h0, lt[i] + 4'h1, 32'h0);
         cfg(0, {6'h0, lt[i]}, 32'h0, 4'h0, 32'h0);
      end
      repeat (4) @(posedge i_clk_sys);
      wrap_up();
   end
endmodule // test_sriov_func_cfg
